// file: include/mtp_pkg.sv
`default_nettype none
package mtp_pkg;

  // ****************************************************************
  // sizes
  // ****************************************************************
  localparam int ADDR_W   = 8;
  localparam int DATA_W   = 16;
  localparam int PRESC_W  = 8;
  localparam int NUM_SUB  = 4;

  // ****************************************************************
  // register offsets (even byte addresses, word registers)
  // ****************************************************************
  localparam logic [ADDR_W-1:0] OFS_PRESC_SUB34  = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_COUNT_BASE   = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_PERCAP_BASE  = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_DTYCAP_BASE  = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_STRIDE       = 8'h02;

  // ****************************************************************
  // field positions and reset values
  // ****************************************************************
  localparam int                PRESC_SUB3_LSB   = 0;
  localparam int                PRESC_SUB4_LSB   = 8;
  localparam logic [DATA_W-1:0] RST_PRESC_SUB34  = 16'h0000;
  localparam logic [DATA_W-1:0] RST_COUNT        = 16'h0000;
  localparam logic [DATA_W-1:0] RST_CAP          = 16'h0000;
  localparam logic [PRESC_W-1:0] RST_PRESC_CNT   = 8'h00;
  localparam logic [DATA_W-1:0] RD_NONE          = 16'h0000;

  // ****************************************************************
  // internal bus request
  // ****************************************************************
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              wr;
    logic              rd;
    logic              word;
    logic [DATA_W-1:0] wdata;
  } mtp_bus_req_s;

endpackage
`default_nettype wire

// file: hw/mtp_prescaler.sv
`timescale 1ns/1ps
`default_nettype none
module mtp_prescaler #(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rst,
  // control
  input  wire logic         run,
  input  wire logic [W-1:0] cmp,
  // divided enable
  output logic              tick
);

  logic [W-1:0] pcnt_reg;

  assign tick = run && (pcnt_reg == cmp);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pcnt_reg <= W'(mtp_pkg::RST_PRESC_CNT);
    end else if (!run || tick) begin
      pcnt_reg <= '0;
    end else begin
      pcnt_reg <= pcnt_reg + W'(1);
    end
  end

endmodule // mtp_prescaler
`default_nettype wire

// file: hw/mtp_dbuf.sv
`timescale 1ns/1ps
`default_nettype none
module mtp_dbuf #(
  parameter int W = 16
) (
  // clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rst,
  // software write
  input  wire logic         wr_en,
  input  wire logic [W-1:0] wr_data,
  // subsystem state
  input  wire logic         pwm_mode,
  input  wire logic         halted,
  input  wire logic         boundary,
  // capture
  input  wire logic         cap_en,
  input  wire logic [W-1:0] cap_data,
  // values
  output logic [W-1:0]      rd_value,
  output logic [W-1:0]      active_value
);

  logic [W-1:0] shadow_reg;
  logic [W-1:0] shadow_next;
  logic [W-1:0] active_reg;

  // capture wins over a same-cycle software write so no event is lost
  always_comb begin
    shadow_next = shadow_reg;
    if (cap_en && !pwm_mode) begin
      shadow_next = cap_data;
    end else if (wr_en) begin
      shadow_next = wr_data;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      shadow_reg <= W'(mtp_pkg::RST_CAP);
    end else begin
      shadow_reg <= shadow_next;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      active_reg <= W'(mtp_pkg::RST_CAP);
    end else if (!pwm_mode || halted || boundary) begin
      active_reg <= shadow_next;
    end
  end

  assign rd_value     = shadow_reg;
  assign active_value = active_reg;

endmodule // mtp_dbuf
`default_nettype wire

// file: hw/mtp_timer.sv
//Contract
// - Each subsystem counter advances once per prescaler match, dividing the clock by compare plus one.
// - The second prescaler register holds subsystem three's compare in its low byte and four's in its high byte.
// - Reset clears both byte fields of the second prescaler register.
// - Four word counter registers exist, one per subsystem, all cleared at reset.
// - A counter read at any time returns the live count and does not disturb counting.
// - A counter may be written only while both of its run-control bits are zero.
// - Period/capture registers hold the period in pulse-width mode and otherwise the last captured count.
// - A period written while counting becomes active at a match with the old period or when halted.
// - Reading a period or duty register returns the latest written value even if not yet active.
// - All four period/capture registers clear at reset.
// - Four duty/capture registers hold the duty compare in pulse-width mode, else the last capture.
// - A duty value written while counting in pulse-width mode moves to the active compare only at a period boundary or halt.
// - Byte-sized data uses only the lowest eight lines of the internal data bus.
`timescale 1ns/1ps
`default_nettype none
module mtp_timer #(
  parameter int NUM_SUB = mtp_pkg::NUM_SUB,
  parameter int DATA_W  = mtp_pkg::DATA_W,
  parameter int PRESC_W = mtp_pkg::PRESC_W
) (
  // clock and reset
  input  wire logic                       sys_clk,
  input  wire logic                       rst,
  // internal bus
  input  wire mtp_pkg::mtp_bus_req_s      bus_req,
  output logic [DATA_W-1:0]               bus_rdata,
  // run control and mode, from the timer control registers
  input  wire logic [NUM_SUB-1:0][1:0]    run_control_bit,
  input  wire logic [NUM_SUB-1:0]         pwm_mode,
  input  wire logic [2*PRESC_W-1:0]       prescale_cmp_sub12,
  // capture events
  input  wire logic [NUM_SUB-1:0]         cap_period_ev,
  input  wire logic [NUM_SUB-1:0]         cap_duty_ev,
  // timer outputs
  output logic [NUM_SUB-1:0]              pwm_out,
  output logic [NUM_SUB-1:0]              period_match
);

  // ****************************************************************
  // bus qualification
  // ****************************************************************
  // word registers only answer to word transactions at even addresses
  logic bus_ok;
  logic wr_ok;
  logic rd_ok;

  assign bus_ok = bus_req.word && !bus_req.addr[0];
  assign wr_ok  = bus_req.wr && bus_ok;
  assign rd_ok  = bus_req.rd && bus_ok;

  // ****************************************************************
  // second prescaler register
  // ****************************************************************
  logic [DATA_W-1:0] prescale_cmp_sub34_reg;
  logic              presc_hit;

  assign presc_hit = (bus_req.addr == mtp_pkg::OFS_PRESC_SUB34);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      prescale_cmp_sub34_reg <= mtp_pkg::RST_PRESC_SUB34;
    end else if (wr_ok && presc_hit) begin
      prescale_cmp_sub34_reg <= bus_req.wdata;
    end
  end

  logic [NUM_SUB-1:0][PRESC_W-1:0] presc_cmp;

  assign presc_cmp[0] = prescale_cmp_sub12[PRESC_W-1:0];
  assign presc_cmp[1] = prescale_cmp_sub12[2*PRESC_W-1:PRESC_W];
  assign presc_cmp[2] =
    prescale_cmp_sub34_reg[mtp_pkg::PRESC_SUB3_LSB +: PRESC_W];
  assign presc_cmp[3] =
    prescale_cmp_sub34_reg[mtp_pkg::PRESC_SUB4_LSB +: PRESC_W];

  // ****************************************************************
  // subsystems
  // ****************************************************************
  logic [NUM_SUB-1:0][DATA_W-1:0] count_reg;
  logic [NUM_SUB-1:0][DATA_W-1:0] per_rd;
  logic [NUM_SUB-1:0][DATA_W-1:0] dty_rd;
  logic [NUM_SUB-1:0]             cnt_hit;
  logic [NUM_SUB-1:0]             per_hit;
  logic [NUM_SUB-1:0]             dty_hit;

  genvar n;
  generate
    for (n = 0; n < NUM_SUB; n++) begin : g_sub
      logic              running;
      logic              tick;
      logic              boundary;
      logic [DATA_W-1:0] per_act;
      logic [DATA_W-1:0] dty_act;

      assign running = |run_control_bit[n];
      assign cnt_hit[n] = (bus_req.addr ==
        mtp_pkg::ADDR_W'(mtp_pkg::OFS_COUNT_BASE + mtp_pkg::OFS_STRIDE * n));
      assign per_hit[n] = (bus_req.addr ==
        mtp_pkg::ADDR_W'(mtp_pkg::OFS_PERCAP_BASE + mtp_pkg::OFS_STRIDE * n));
      assign dty_hit[n] = (bus_req.addr ==
        mtp_pkg::ADDR_W'(mtp_pkg::OFS_DTYCAP_BASE + mtp_pkg::OFS_STRIDE * n));

      mtp_prescaler #(
        .W (PRESC_W)
      ) u_presc (
        .sys_clk (sys_clk),
        .rst     (rst),
        .run     (running),
        .cmp     (presc_cmp[n]),
        .tick    (tick)
      );

      // period boundary: count meets the active period on a tick
      assign boundary = pwm_mode[n] && tick && (count_reg[n] == per_act);

      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          count_reg[n] <= mtp_pkg::RST_COUNT;
        end else if (!running) begin
          if (wr_ok && cnt_hit[n]) begin
            count_reg[n] <= bus_req.wdata;
          end
        end else if (boundary) begin
          count_reg[n] <= '0;
        end else if (tick) begin
          count_reg[n] <= count_reg[n] + DATA_W'(1);
        end
      end

      mtp_dbuf #(
        .W (DATA_W)
      ) u_per (
        .sys_clk      (sys_clk),
        .rst          (rst),
        .wr_en        (wr_ok && per_hit[n]),
        .wr_data      (bus_req.wdata),
        .pwm_mode     (pwm_mode[n]),
        .halted       (!running),
        .boundary     (boundary),
        .cap_en       (cap_period_ev[n]),
        .cap_data     (count_reg[n]),
        .rd_value     (per_rd[n]),
        .active_value (per_act)
      );

      mtp_dbuf #(
        .W (DATA_W)
      ) u_dty (
        .sys_clk      (sys_clk),
        .rst          (rst),
        .wr_en        (wr_ok && dty_hit[n]),
        .wr_data      (bus_req.wdata),
        .pwm_mode     (pwm_mode[n]),
        .halted       (!running),
        .boundary     (boundary),
        .cap_en       (cap_duty_ev[n]),
        .cap_data     (count_reg[n]),
        .rd_value     (dty_rd[n]),
        .active_value (dty_act)
      );

      // pwm level is high while the count is below the duty compare
      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          pwm_out[n] <= 1'b0;
        end else begin
          pwm_out[n] <= pwm_mode[n] && running && (count_reg[n] < dty_act);
        end
      end

      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          period_match[n] <= 1'b0;
        end else begin
          period_match[n] <= boundary;
        end
      end
    end
  endgenerate

  // ****************************************************************
  // read path
  // ****************************************************************
  logic [DATA_W-1:0] rd_next;

  always_comb begin
    rd_next = mtp_pkg::RD_NONE;
    if (presc_hit) begin
      rd_next = prescale_cmp_sub34_reg;
    end else begin
      for (int i = 0; i < NUM_SUB; i++) begin
        if (cnt_hit[i]) begin
          rd_next = count_reg[i];
        end else if (per_hit[i]) begin
          rd_next = per_rd[i];
        end else if (dty_hit[i]) begin
          rd_next = dty_rd[i];
        end
      end
    end
  end

  // unmapped or non-word reads return zero instead of bus garbage
  // no byte-lane registers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bus_rdata <= mtp_pkg::RD_NONE;
    end else if (rd_ok) begin
      bus_rdata <= rd_next;
    end else if (bus_req.rd) begin
      bus_rdata <= mtp_pkg::RD_NONE;
    end
  end

endmodule // mtp_timer
`default_nettype wire

// file: tb/mtp_timer_props.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// port checker
// ****
module mtp_timer_props #(
  parameter int NUM_SUB = mtp_pkg::NUM_SUB,
  parameter int DATA_W  = mtp_pkg::DATA_W,
  parameter int PRESC_W = mtp_pkg::PRESC_W
) (
  // clock and reset
  input wire logic                    sys_clk,
  input wire logic                    rst,
  // bus
  input wire mtp_pkg::mtp_bus_req_s   bus_req,
  input wire logic [DATA_W-1:0]       bus_rdata,
  // control
  input wire logic [NUM_SUB-1:0][1:0] run_control_bit,
  input wire logic [NUM_SUB-1:0]      pwm_mode,
  input wire logic [2*PRESC_W-1:0]    prescale_cmp_sub12,
  input wire logic [NUM_SUB-1:0]      cap_period_ev,
  input wire logic [NUM_SUB-1:0]      cap_duty_ev,
  // outputs
  input wire logic [NUM_SUB-1:0]      pwm_out,
  input wire logic [NUM_SUB-1:0]      period_match
);
  logic [NUM_SUB-1:0] run_any;
  always_comb begin
    for (int i = 0; i < NUM_SUB; i++) begin
      run_any[i] = |run_control_bit[i];
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // outputs may lag their cause by one or two cycles
  property p_rd_hold; !bus_req.rd |=> $stable(bus_rdata); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("rdata moved");
  property p_byte_rd; bus_req.rd && !bus_req.word |=> bus_rdata == '0; endproperty
  a_byte_rd: assert property (p_byte_rd) else $error("byte read data");
  property p_odd_rd; bus_req.rd && bus_req.addr[0] |=> bus_rdata == '0; endproperty
  a_odd_rd: assert property (p_odd_rd) else $error("odd read data");
  property p_unmap_rd;
    bus_req.rd && !(bus_req.addr inside {8'h08, [8'h10:8'h26]}) |=> bus_rdata == '0;
  endproperty
  a_unmap_rd: assert property (p_unmap_rd) else $error("unmapped read data");
  // the bench leaves one idle cycle between transfers
  sequence s_wr_rd;
    (bus_req.wr && bus_req.word && bus_req.addr == 8'h18 && !cap_period_ev[0]) ##1
    (!bus_req.wr && !cap_period_ev[0]) ##1
    (bus_req.rd && !bus_req.wr && bus_req.word && bus_req.addr == 8'h18 && !cap_period_ev[0]);
  endsequence
  property p_wr_rd; s_wr_rd |=> bus_rdata == $past(bus_req.wdata, 3); endproperty
  a_wr_rd: assert property (p_wr_rd) else $error("readback differs");
  property p_pwm_mode; (pwm_out & ~($past(pwm_mode) | $past(pwm_mode, 2))) == '0; endproperty
  a_pwm_mode: assert property (p_pwm_mode) else $error("pwm out in capture");
  property p_pwm_run; (pwm_out & ~($past(run_any) | $past(run_any, 2))) == '0; endproperty
  a_pwm_run: assert property (p_pwm_run) else $error("pwm out halted");
  property p_pm_mode;
    (period_match & ~($past(pwm_mode) | $past(pwm_mode, 2))) == '0;
  endproperty
  a_pm_mode: assert property (p_pm_mode) else $error("match in capture");
  property p_pm_run; (period_match & ~($past(run_any) | $past(run_any, 2))) == '0; endproperty
  a_pm_run: assert property (p_pm_run) else $error("match halted");
  c_match: cover property (period_match[0]);
  c_pwm: cover property (pwm_out[0]);
  c_wr_rd: cover property (s_wr_rd);
endmodule // mtp_timer_props
bind mtp_timer mtp_timer_props #(.NUM_SUB(NUM_SUB), .DATA_W(DATA_W), .PRESC_W(PRESC_W)) u_props (
  .sys_clk(sys_clk), .rst(rst), .bus_req(bus_req), .bus_rdata(bus_rdata),
  .run_control_bit(run_control_bit), .pwm_mode(pwm_mode),
  .prescale_cmp_sub12(prescale_cmp_sub12), .cap_period_ev(cap_period_ev),
  .cap_duty_ev(cap_duty_ev), .pwm_out(pwm_out), .period_match(period_match));
`default_nettype wire

// file: tb/mtp_timer_bench.sv
`timescale 1ns/1ps
`default_nettype none
module mtp_timer_bench;
  logic                  sys_clk, rst, rd_seen;
  mtp_pkg::mtp_bus_req_s bus_req;
  logic [15:0]           bus_rdata, prescale_cmp_sub12, v;
  logic [3:0][1:0]       run_control_bit;
  logic [3:0]            pwm_mode, cap_period_ev, cap_duty_ev, pwm_out, period_match;
  logic [15:0]           exp_q[$];
  int                    err_count, cmp_count, len, hi;
  mtp_timer dut (.sys_clk(sys_clk), .rst(rst), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .run_control_bit(run_control_bit), .pwm_mode(pwm_mode),
    .prescale_cmp_sub12(prescale_cmp_sub12), .cap_period_ev(cap_period_ev),
    .cap_duty_ev(cap_duty_ev), .pwm_out(pwm_out), .period_match(period_match));
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    cmp_count++;
    if (seen !== want) begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic bus(input logic w, r, wd, input logic [7:0] a, input logic [15:0] d);
    bus_req = '{addr: a, wr: w, rd: r, word: wd, wdata: d};
    @(posedge sys_clk);
    #1;
    // one idle edge between transfers so no strobe is assigned twice at once
    bus_req = '0;
    @(posedge sys_clk);
    #1;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] want, input logic wd = 1'b1);
    exp_q.push_back(want);
    bus(1'b0, 1'b1, wd, a, 16'h0000);
  endtask
  // cycles to the next period pulse, and pwm high cycles within them
  task automatic meas(output int n, output int h);
    n = 0;
    h = 0;
    for (int k = 0; k < 64; k++) begin
      @(posedge sys_clk);
      #1;
      n++;
      h += int'(pwm_out[0]);
      if (period_match[0] === 1'b1) begin
        return;
      end
    end
    err_count++;
    complete_run();
  endtask
  // ****
  // scoreboard: one note per read strobe
  // ****
  always @(posedge sys_clk) begin
    if (rd_seen) begin
      check(bus_rdata, exp_q.pop_front());
    end
    rd_seen <= bus_req.rd;
  end
  initial begin
    void'($urandom(13777));
    {rst, err_count, cmp_count} = {1'b1, 64'd0};
    {bus_req, run_control_bit, pwm_mode, cap_period_ev, cap_duty_ev} = '0;
    prescale_cmp_sub12 = 16'h0900;
    repeat (5) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    rd_chk(8'h08, 16'h0000);
    for (int a = 16; a <= 38; a += 2) begin
      rd_chk(8'(a), 16'h0000);
    end
    v = 16'($urandom);
    bus(1'b1, 1'b0, 1'b1, 8'h08, v);
    rd_chk(8'h08, v);
    bus(1'b1, 1'b0, 1'b0, 8'h08, ~v);
    rd_chk(8'h08, v);
    rd_chk(8'h08, 16'h0000, 1'b0);
    rd_chk(8'h09, 16'h0000);
    rd_chk(8'h00, 16'h0000);
    bus(1'b1, 1'b0, 1'b1, 8'h08, 16'h0402);
    v = 16'($urandom) & 16'h7fff;
    bus(1'b1, 1'b0, 1'b1, 8'h14, v);
    for (int i = 0; i < 4; i++) begin
      run_control_bit[i] = 2'(1 + $urandom % 3);
    end
    // write while running is dropped
    bus(1'b1, 1'b0, 1'b1, 8'h10, 16'habcd);
    // live read: two ticks have passed at compare zero
    rd_chk(8'h10, 16'd2);
    repeat (26) @(posedge sys_clk);
    #1;
    run_control_bit = '0;
    rd_chk(8'h10, 16'd30);
    rd_chk(8'h12, 16'd3);
    rd_chk(8'h14, v + 16'd10);
    rd_chk(8'h16, 16'd6);
    {cap_period_ev, cap_duty_ev} = 8'h22;
    @(posedge sys_clk);
    #1;
    {cap_period_ev, cap_duty_ev} = 8'h00;
    rd_chk(8'h1a, 16'd3);
    rd_chk(8'h22, 16'd3);
    bus(1'b1, 1'b0, 1'b1, 8'h10, 16'h0000);
    pwm_mode = 4'h1;
    bus(1'b1, 1'b0, 1'b1, 8'h18, 16'h0007);
    bus(1'b1, 1'b0, 1'b1, 8'h20, 16'h0003);
    run_control_bit[0] = 2'b01;
    meas(len, hi);
    meas(len, hi);
    check(16'(len), 16'd8);
    check(16'(hi), 16'd3);
    bus(1'b1, 1'b0, 1'b1, 8'h18, 16'h0009);
    rd_chk(8'h18, 16'h0009);
    bus(1'b1, 1'b0, 1'b1, 8'h20, 16'h0004);
    rd_chk(8'h20, 16'h0004);
    // the old period ends while the reads run, so the next one is new
    meas(len, hi);
    check(16'(len), 16'd10);
    meas(len, hi);
    check(16'(len), 16'd10);
    check(16'(hi), 16'd4);
    {run_control_bit, pwm_mode} = '0;
    // mid-run reset must clear what the run left behind
    rst = 1'b1;
    repeat (2) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    rd_chk(8'h08, 16'h0000);
    rd_chk(8'h14, 16'h0000);
    rd_chk(8'h18, 16'h0000);
    rd_chk(8'h20, 16'h0000);
    repeat (2) @(posedge sys_clk);
    complete_run();
  end
endmodule // mtp_timer_bench
`default_nettype wire
